// ===== rtl/adc_calibration_sequencer.sv
// Calibration and conversion sequencer of a 12-bit sampling converter.
// Assumes cal_req_n, convert_trigger_n, sleep_n and master_clock_in are pins
// from outside the clk domain; ctrl_wr and ctrl come from logic on clk.
//
// Operation
// - Start by pin pulse or start bit
// - Pin low resets core before calibration
// - Busy rises at pin rise or write
// - Full calibration busy until finished
// - Other self calibrations busy, length by type
// - Durations fixed master clock counts
// - Pin held low at power-on: auto calibration
// - Power-on calibration lasts 32 ms
// - Full: capacitor array, then gain, offset
// - Gain then offset, no array trim
// - Offset only or gain only trim
// - Offset trims zero, gain trims full scale
// - System trim covers 5 and 2.5 percent
// - Out of range errors saturate, finish
// - Negative offsets corrected too
// - Conversion 4.6 us, powered only when needed
// - Pin tied high suppresses auto calibration
// - Sleep ignored from strap sample until power-on calibration ends
`include "adc_cal_defs.svh"
`timescale 1ns/100ps

module adc_calibration_sequencer
  import adc_cal_pkg::*;
#(
  parameter int unsigned CNT_W = 17,
  parameter int unsigned CAL_FULL_CYC = 32'(`CAL_FULL_MCLK),
  parameter int unsigned CAL_GO_CYC = 32'(`CAL_GO_MCLK),
  parameter int unsigned CAL_SINGLE_CYC = 32'(`CAL_SINGLE_MCLK),
  parameter int unsigned CAL_POR_CYC = 32'(`CAL_POR_MCLK),
  parameter int unsigned CONV_CYC = 32'(`CONV_MCLK),
  parameter int unsigned PWRUP_CYC = 32'(`PWRUP_MCLK)
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic cal_req_n,
  input wire logic master_clock_in,
  input wire logic convert_trigger_n,
  input wire logic sleep_n,
  input wire logic pd_after_conv,
  input wire logic ctrl_wr,
  input wire ctrl_write_s ctrl,
  input wire logic signed [11:0] err_sample,
  output logic busy,
  output logic core_reset,
  output cal_phase_s phase,
  output logic power_on,
  output logic cal_done,
  output logic signed [8:0] offset_trim,
  output logic signed [7:0] gain_trim
);

  // ----------------------------------------------------------------------
  // Types and constants
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DAC,
    ST_GAIN,
    ST_OFFS,
    ST_CONV
  } seq_state_e;

  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] cal_sync_ff; // Calibration pin, bit 1 is safe
  logic [1:0] conv_sync_ff; // Convert pin
  logic [1:0] sleep_sync_ff; // Sleep pin
  logic [1:0] mclk_sync_ff; // Master clock
  logic cal_dly_ff; // Delayed safe calibration pin
  logic conv_dly_ff; // Delayed safe convert pin
  logic mclk_dly_ff; // Delayed safe master clock
  logic [1:0] nxt_cal_sync;
  logic [1:0] nxt_conv_sync;
  logic [1:0] nxt_sleep_sync;
  logic [1:0] nxt_mclk_sync;
  logic nxt_cal_dly;
  logic nxt_conv_dly;
  logic nxt_mclk_dly;

  // Next values: two stages, then one delay stage for edge detection
  always_comb begin
    nxt_cal_sync = {cal_sync_ff[0], cal_req_n};
    nxt_conv_sync = {conv_sync_ff[0], convert_trigger_n};
    nxt_sleep_sync = {sleep_sync_ff[0], sleep_n};
    nxt_mclk_sync = {mclk_sync_ff[0], master_clock_in};
    nxt_cal_dly = cal_sync_ff[1];
    nxt_conv_dly = conv_sync_ff[1];
    nxt_mclk_dly = mclk_sync_ff[1];
  end

  // Registers; pins idle high, clock idles low
  always_ff @(posedge clk) begin
    if (srst) begin
      cal_sync_ff <= 2'h3;
      conv_sync_ff <= 2'h3;
      sleep_sync_ff <= 2'h3;
      mclk_sync_ff <= 2'h0;
      cal_dly_ff <= 1'b1;
      conv_dly_ff <= 1'b1;
      mclk_dly_ff <= 1'b0;
    end else begin
      cal_sync_ff <= nxt_cal_sync;
      conv_sync_ff <= nxt_conv_sync;
      sleep_sync_ff <= nxt_sleep_sync;
      mclk_sync_ff <= nxt_mclk_sync;
      cal_dly_ff <= nxt_cal_dly;
      conv_dly_ff <= nxt_conv_dly;
      mclk_dly_ff <= nxt_mclk_dly;
    end
  end

  // Edge events taken from the safe stages only
  logic cal_rise; // Calibration pin released
  logic conv_fall; // Convert pin pulled low
  logic conv_rise; // Convert pin released
  logic mclk_tick; // Master clock rising edge
  assign cal_rise = cal_sync_ff[1] & ~cal_dly_ff;
  assign conv_fall = ~conv_sync_ff[1] & conv_dly_ff;
  assign conv_rise = conv_sync_ff[1] & ~conv_dly_ff;
  assign mclk_tick = mclk_sync_ff[1] & ~mclk_dly_ff;

  // ----------------------------------------------------------------------
  // Power-on strap capture
  // ----------------------------------------------------------------------
  logic [1:0] strap_cnt_ff; // Settle count after reset release
  logic strap_done_ff; // Strap has been sampled
  logic por_armed_ff; // Pin was low at power-on
  logic por_run_ff; // Power-on calibration in progress
  logic [1:0] nxt_strap_cnt;
  logic nxt_strap_done;
  logic nxt_por_armed;
  logic nxt_por_run;
  logic seq_end; // Last phase of a calibration ends
  logic por_start; // Power-on calibration launched

  // Pin low when sampled arms the automatic calibration; high suppresses it
  always_comb begin
    nxt_strap_cnt = strap_cnt_ff;
    nxt_strap_done = strap_done_ff;
    nxt_por_armed = por_armed_ff;
    nxt_por_run = por_run_ff;
    if (!strap_done_ff) begin
      nxt_strap_cnt = strap_cnt_ff + 2'h1;
      if (strap_cnt_ff == `STRAP_WAIT) begin
        nxt_strap_done = 1'b1;
        nxt_por_armed = ~cal_sync_ff[1];
      end
    end
    if (por_start) begin
      nxt_por_armed = 1'b0;
      nxt_por_run = 1'b1;
    end else if (seq_end) begin
      nxt_por_run = 1'b0;
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    if (srst) begin
      strap_cnt_ff <= 2'h0;
      strap_done_ff <= 1'b0;
      por_armed_ff <= 1'b0;
      por_run_ff <= 1'b0;
    end else begin
      strap_cnt_ff <= nxt_strap_cnt;
      strap_done_ff <= nxt_strap_done;
      por_armed_ff <= nxt_por_armed;
      por_run_ff <= nxt_por_run;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  seq_state_e state_ff; // Current phase
  cal_sel_e sel_ff; // Type of the running calibration
  logic [CNT_W-1:0] cnt_ff; // Master clock cycles left in phase
  logic [CNT_W-1:0] gain_cnt_ff; // Gain phase length
  logic [CNT_W-1:0] offs_cnt_ff; // Offset phase length
  logic busy_ff;
  logic core_reset_ff;
  cal_phase_s phase_ff;
  logic cal_done_ff;
  logic signed [8:0] offset_trim_ff;
  logic signed [7:0] gain_trim_ff;
  logic power_on_ff; // Core supply enable
  logic nxt_power_on;
  seq_state_e nxt_state;
  cal_sel_e nxt_sel;
  logic [CNT_W-1:0] nxt_cnt;
  logic [CNT_W-1:0] nxt_gain_cnt;
  logic [CNT_W-1:0] nxt_offs_cnt;
  logic nxt_busy;
  logic nxt_core_reset;
  cal_phase_s nxt_phase;
  logic nxt_cal_done;
  logic signed [8:0] nxt_offset_trim;
  logic signed [7:0] nxt_gain_trim;
  logic phase_end; // Current phase count runs out
  logic cal_start; // A calibration is accepted
  logic signed [12:0] corr; // Correction, negated error
  logic signed [12:0] offs_sat; // Offset correction within range
  logic signed [12:0] gain_sat; // Gain correction within range

  assign phase_end = mclk_tick & (cnt_ff == CNT_ONE);
  assign cal_start = (state_ff == ST_IDLE) & (cal_rise | (ctrl_wr & ctrl.start_calibration_bit));
  assign por_start = cal_start & cal_rise & por_armed_ff;
  assign corr = -13'(err_sample);

  // Saturate the corrections at the trim limits, either sign
  always_comb begin
    offs_sat = corr;
    gain_sat = corr;
    if (corr > $signed(`OFFS_LIM)) begin
      offs_sat = $signed(`OFFS_LIM);
    end else if (corr < -$signed(`OFFS_LIM)) begin
      offs_sat = -$signed(`OFFS_LIM);
    end
    if (corr > $signed(`GAIN_LIM)) begin
      gain_sat = $signed(`GAIN_LIM);
    end else if (corr < -$signed(`GAIN_LIM)) begin
      gain_sat = -$signed(`GAIN_LIM);
    end
  end

  // Next state of the sequence, counts, flags and trims
  always_comb begin
    nxt_state = state_ff;
    nxt_sel = sel_ff;
    nxt_cnt = cnt_ff;
    nxt_gain_cnt = gain_cnt_ff;
    nxt_offs_cnt = offs_cnt_ff;
    nxt_cal_done = 1'b0;
    nxt_offset_trim = offset_trim_ff;
    nxt_gain_trim = gain_trim_ff;
    seq_end = 1'b0;
    if (mclk_tick && cnt_ff != '0) begin
      nxt_cnt = cnt_ff - CNT_ONE;
    end
    case (state_ff)
      ST_IDLE: begin
        if (cal_start) begin
          // Pin start uses the held field; software uses the written one
          nxt_sel = cal_rise ? sel_ff : ctrl.cal_sel;
          if (por_start) begin
            nxt_sel = CAL_FULL_SELF;
          end
          nxt_gain_cnt = CNT_W'(CAL_SINGLE_CYC);
          nxt_offs_cnt = CNT_W'(CAL_SINGLE_CYC);
          case (nxt_sel)
            CAL_FULL_SELF: begin
              nxt_state = ST_DAC;
              nxt_cnt = por_start ? CNT_W'(CAL_POR_CYC - CAL_GO_CYC) : CNT_W'(CAL_FULL_CYC - CAL_GO_CYC);
              nxt_offs_cnt = CNT_W'(CAL_GO_CYC - CAL_SINGLE_CYC);
            end
            CAL_GAIN_OFFS_SELF: begin
              nxt_state = ST_GAIN;
              nxt_cnt = CNT_W'(CAL_SINGLE_CYC);
              nxt_offs_cnt = CNT_W'(CAL_GO_CYC - CAL_SINGLE_CYC);
            end
            CAL_OFFS_SELF, CAL_OFFS_SYS: begin
              nxt_state = ST_OFFS;
              nxt_cnt = CNT_W'(CAL_SINGLE_CYC);
            end
            CAL_GAIN_SELF, CAL_GAIN_SYS: begin
              nxt_state = ST_GAIN;
              nxt_cnt = CNT_W'(CAL_SINGLE_CYC);
            end
            default: begin
              nxt_state = ST_DAC;
              nxt_cnt = CNT_W'(CAL_FULL_CYC - CAL_GO_CYC);
              nxt_offs_cnt = CNT_W'(CAL_GO_CYC - CAL_SINGLE_CYC);
            end
          endcase
        end else if (conv_rise || (ctrl_wr && ctrl.start_conv)) begin
          // Add the power-up interval when the core was down
          nxt_state = ST_CONV;
          nxt_cnt = power_on_ff ? CNT_W'(CONV_CYC) : CNT_W'(CONV_CYC + PWRUP_CYC);
        end
      end
      ST_DAC: begin
        if (phase_end) begin
          nxt_state = ST_GAIN;
          nxt_cnt = gain_cnt_ff;
        end
      end
      ST_GAIN: begin
        if (phase_end) begin
          nxt_gain_trim = 8'(gain_sat);
          if (sel_ff == CAL_GAIN_SELF || sel_ff == CAL_GAIN_SYS) begin
            nxt_state = ST_IDLE;
            nxt_cal_done = 1'b1;
            seq_end = 1'b1;
          end else begin
            nxt_state = ST_OFFS;
            nxt_cnt = offs_cnt_ff;
          end
        end
      end
      ST_OFFS: begin
        if (phase_end) begin
          nxt_offset_trim = 9'(offs_sat);
          nxt_state = ST_IDLE;
          nxt_cal_done = 1'b1;
          seq_end = 1'b1;
        end
      end
      ST_CONV: begin
        if (phase_end) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // Busy follows the state about to be entered
    nxt_busy = (nxt_state != ST_IDLE);
    nxt_core_reset = ~cal_sync_ff[1] & (nxt_state == ST_IDLE);
    nxt_phase.dac_trim = (nxt_state == ST_DAC);
    nxt_phase.gain_trim = (nxt_state == ST_GAIN);
    nxt_phase.offs_trim = (nxt_state == ST_OFFS);
    nxt_phase.converting = (nxt_state == ST_CONV);
  end

  // Registers
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= ST_IDLE;
      sel_ff <= CAL_FULL_SELF;
      cnt_ff <= '0;
      gain_cnt_ff <= '0;
      offs_cnt_ff <= '0;
      busy_ff <= 1'b0;
      core_reset_ff <= 1'b0;
      phase_ff <= '0;
      cal_done_ff <= 1'b0;
      offset_trim_ff <= '0;
      gain_trim_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      sel_ff <= nxt_sel;
      cnt_ff <= nxt_cnt;
      gain_cnt_ff <= nxt_gain_cnt;
      offs_cnt_ff <= nxt_offs_cnt;
      busy_ff <= nxt_busy;
      core_reset_ff <= nxt_core_reset;
      phase_ff <= nxt_phase;
      cal_done_ff <= nxt_cal_done;
      offset_trim_ff <= nxt_offset_trim;
      gain_trim_ff <= nxt_gain_trim;
    end
  end

  // ----------------------------------------------------------------------
  // Power control
  // ----------------------------------------------------------------------
  logic pd_wanted; // Idle power-down requested

  // Down when idle and asked to, never between the strap sample and the end of power-on calibration
  always_comb begin
    pd_wanted = pd_after_conv | ~sleep_sync_ff[1];
    if (por_armed_ff || por_run_ff) begin
      pd_wanted = 1'b0;
    end
    nxt_power_on = 1'b1;
    if (pd_wanted && nxt_state == ST_IDLE) begin
      // Convert pin held low powers up ahead of the conversion
      nxt_power_on = ~conv_sync_ff[1] & ~conv_fall | (power_on_ff & ~conv_sync_ff[1]);
      if (!conv_sync_ff[1] && conv_fall) begin
        nxt_power_on = 1'b1;
      end
    end
  end

  // Register
  always_ff @(posedge clk) begin
    if (srst) begin
      power_on_ff <= 1'b1;
    end else begin
      power_on_ff <= nxt_power_on;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign busy = busy_ff;
  assign core_reset = core_reset_ff;
  assign phase = phase_ff;
  assign power_on = power_on_ff;
  assign cal_done = cal_done_ff;
  assign offset_trim = offset_trim_ff;
  assign gain_trim = gain_trim_ff;

endmodule : adc_calibration_sequencer

// ===== rtl/adc_cal_defs.svh
// Offsets-free constant set for the calibration sequencer: times and counts.
// Assumes the master clock figures below; counts are in master clock cycles.
`ifndef ADC_CAL_DEFS_SVH
`define ADC_CAL_DEFS_SVH

// ----------------------------------------------------------------------
// Master clock rate
// ----------------------------------------------------------------------
`define MCLK_MHZ 64'd4

// ----------------------------------------------------------------------
// Times as printed, in ns
// ----------------------------------------------------------------------
`define CAL_FULL_NS 64'd31250000
`define CAL_GO_NS 64'd6940000
`define CAL_SINGLE_NS 64'd3470000
`define CAL_POR_NS 64'd32000000
`define CONV_NS 64'd4600
`define PWRUP_NS 64'd5000

// ----------------------------------------------------------------------
// Derived master clock counts (longest round down, least round up)
// ----------------------------------------------------------------------
`define CAL_FULL_MCLK ((`CAL_FULL_NS * `MCLK_MHZ) / 64'd1000)
`define CAL_GO_MCLK ((`CAL_GO_NS * `MCLK_MHZ) / 64'd1000)
`define CAL_SINGLE_MCLK ((`CAL_SINGLE_NS * `MCLK_MHZ) / 64'd1000)
`define CAL_POR_MCLK ((`CAL_POR_NS * `MCLK_MHZ) / 64'd1000)
`define CONV_MCLK ((`CONV_NS * `MCLK_MHZ) / 64'd1000)
`define PWRUP_MCLK ((`PWRUP_NS * `MCLK_MHZ + 64'd999) / 64'd1000)

// ----------------------------------------------------------------------
// Trim limits in LSB of a 4096-code range and start-up settle cycles
// ----------------------------------------------------------------------
`define OFFS_LIM 13'h0CC
`define GAIN_LIM 13'h066
`define STRAP_WAIT 2'h3

`endif

// ===== rtl/adc_cal_pkg.sv
// Types shared by the calibration sequencer and its users.
// Assumes nothing beyond a SystemVerilog compiler.
package adc_cal_pkg;

  // ----------------------------------------------------------------------
  // Calibration type select, in field order 0..5
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    CAL_FULL_SELF,
    CAL_GAIN_OFFS_SELF,
    CAL_OFFS_SELF,
    CAL_GAIN_SELF,
    CAL_OFFS_SYS,
    CAL_GAIN_SYS
  } cal_sel_e;

  // Control write contents from the serial port logic
  typedef struct packed {
    logic start_calibration_bit;
    cal_sel_e cal_sel;
    logic start_conv;
  } ctrl_write_s;

  // Active phase flags driven to the analog trim logic
  typedef struct packed {
    logic dac_trim;
    logic gain_trim;
    logic offs_trim;
    logic converting;
  } cal_phase_s;

endpackage : adc_cal_pkg

// ===== tb/adc_cal_seq_sva.sv
// Port checker for the calibration sequencer.
// Assumes it is bound to the sequencer top; one clock domain.
`timescale 1ns/100ps

module adc_cal_seq_sva
  import adc_cal_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ctrl_wr,
  input wire ctrl_write_s ctrl,
  input wire logic busy,
  input wire logic core_reset,
  input wire cal_phase_s phase,
  input wire logic power_on,
  input wire logic cal_done,
  input wire logic signed [8:0] offset_trim,
  input wire logic signed [7:0] gain_trim
);
  // ----------------------------------------------------------------------
  // Age since reset release, so early strap cycles are skipped
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  logic [3:0] age_ff;
  logic [3:0] nxt_age;
  // Saturating count of edges after reset
  always_comb begin
    nxt_age = age_ff;
    if (srst) begin
      nxt_age = 4'h0;
    end else if (age_ff != 4'hF) begin
      nxt_age = age_ff + 4'h1;
    end
  end
  // Register only
  always_ff @(posedge clk) begin
    age_ff <= nxt_age;
  end
  a_reset_vals: assert property ($past(srst) |-> !busy && !cal_done && power_on && phase == 4'h0)
    else $error("outputs not at reset values");
  a_soft_start: assert property (ctrl_wr && ctrl.start_calibration_bit && !busy && !core_reset && age_ff > 4'h6 |=> busy)
    else $error("start bit did not raise busy");
  a_done_ends: assert property (cal_done |-> !busy && $past(busy))
    else $error("done without busy fall");
  a_done_pulse: assert property (cal_done |=> !cal_done)
    else $error("done longer than one cycle");
  a_phase_onehot: assert property ($onehot0(phase))
    else $error("two phases at once");
  a_phase_busy: assert property (phase != 4'h0 |-> busy)
    else $error("phase without busy");
  a_core_idle: assert property (core_reset |-> !busy)
    else $error("core reset while busy");
  a_offs_range: assert property (offset_trim <= 9'sd204 && offset_trim >= -9'sd204)
    else $error("offset trim beyond limit");
  a_gain_range: assert property (gain_trim <= 8'sd102 && gain_trim >= -8'sd102)
    else $error("gain trim beyond limit");
  a_trim_phase: assert property ($changed(offset_trim) |-> $past(phase.offs_trim))
    else $error("offset trim moved outside offset phase");
  a_busy_power: assert property ($rose(busy) |=> power_on)
    else $error("busy while powered down");
  a_busy_min: assert property ($rose(busy) |-> busy [*3])
    else $error("busy pulse too short");
endmodule : adc_cal_seq_sva

bind adc_calibration_sequencer adc_cal_seq_sva u_adc_cal_seq_sva (.clk(clk), .srst(srst), .ctrl_wr(ctrl_wr),
  .ctrl(ctrl), .busy(busy), .core_reset(core_reset), .phase(phase), .power_on(power_on),
  .cal_done(cal_done), .offset_trim(offset_trim), .gain_trim(gain_trim));

// ===== tb/host_model.sv
// Host side model: calibration, convert and sleep pins, master clock.
// Assumes the bench calls its tasks; pins change just after clk rises.
`timescale 1ns/100ps

module host_model (
  input wire logic clk,
  output logic cal_req_n,
  output logic convert_trigger_n,
  output logic sleep_n,
  output logic master_clock_in
);
  // Master clock, four clk cycles a period
  initial begin
    master_clock_in = 1'b0;
    forever #10 master_clock_in = ~master_clock_in;
  end
  // Pins idle high, calibration pin tied high by default
  initial begin
    cal_req_n = 1'b1;
    convert_trigger_n = 1'b1;
    sleep_n = 1'b1;
  end
  // Calibration pin level
  task automatic set_cal(input logic v);
    @(posedge clk);
    #1 cal_req_n = v;
  endtask : set_cal
  // Sleep pin level
  task automatic set_sleep(input logic v);
    @(posedge clk);
    #1 sleep_n = v;
  endtask : set_sleep
  // Convert pulse, low long enough for power-up
  task automatic conv_pulse(input int lo);
    @(posedge clk);
    #1 convert_trigger_n = 1'b0;
    repeat (lo) @(posedge clk);
    #1 convert_trigger_n = 1'b1;
  endtask : conv_pulse
endmodule : host_model

// ===== tb/adc_calibration_sequencer_tb_top.sv
// Bench for the calibration sequencer with shortened counts.
// Assumes the host model drives the pins; bench drives the rest.
`timescale 1ns/100ps

module adc_calibration_sequencer_tb_top
  import adc_cal_pkg::*;
;
  localparam int FULL = 40;
  localparam int GO = 12;
  localparam int SGL = 5;
  localparam int POR = 44;
  localparam int CONV = 18;
  localparam int PWRUP = 20;
  logic clk, srst, ctrl_wr, pd_after_conv, busy, core_reset, power_on, cal_done;
  logic cal_req_n, convert_trigger_n, sleep_n, master_clock_in;
  logic signed [11:0] err_sample;
  logic signed [8:0] offset_trim;
  logic signed [7:0] gain_trim;
  ctrl_write_s ctrl;
  cal_phase_s phase;
  int err_total, check_count, ed;
  logic [15:0] ord;
  bit dn, pw_drop;
  int lens[7] = '{FULL, GO, SGL, SGL, SGL, SGL, FULL};
  logic [15:0] ords[7] = '{16'h0842, 16'h0042, 16'h0002, 16'h0004, 16'h0002, 16'h0004, 16'h0842};
  logic signed [11:0] errs[7] = '{12'h000, 12'h000, 12'hC18, 12'h1F4, 12'h032, 12'hFE2, 12'h000};
  logic signed [8:0] offs[7] = '{9'h000, 9'h000, 9'h0CC, 9'h0CC, 9'h1CE, 9'h1CE, 9'h000};
  logic signed [7:0] gains[7] = '{8'h00, 8'h00, 8'h00, 8'h9A, 8'h9A, 8'h1E, 8'h00};

  adc_calibration_sequencer #(.CAL_FULL_CYC(FULL), .CAL_GO_CYC(GO), .CAL_SINGLE_CYC(SGL),
    .CAL_POR_CYC(POR)) u_adc_calibration_sequencer (.clk(clk),
    .srst(srst), .cal_req_n(cal_req_n), .master_clock_in(master_clock_in),
    .convert_trigger_n(convert_trigger_n), .sleep_n(sleep_n), .pd_after_conv(pd_after_conv),
    .ctrl_wr(ctrl_wr), .ctrl(ctrl), .err_sample(err_sample), .busy(busy), .core_reset(core_reset),
    .phase(phase), .power_on(power_on), .cal_done(cal_done), .offset_trim(offset_trim),
    .gain_trim(gain_trim));
  host_model u_host_model (.clk(clk), .cal_req_n(cal_req_n), .convert_trigger_n(convert_trigger_n),
    .sleep_n(sleep_n), .master_clock_in(master_clock_in));

  // ----------------------------------------------------------------------
  // Clock, compare and verdict
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  // Synchronous reset held 20 cycles
  task automatic do_reset();
    @(posedge clk);
    #1 srst = 1'b1;
    repeat (20) @(posedge clk);
    #1 srst = 1'b0;
  endtask : do_reset
  // Wait up to n cycles for busy
  task automatic wait_busy(input int n);
    for (int i = 0; i < n && busy !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
  endtask : wait_busy
  // Follow one busy run; optional refused request in mid-run
  task automatic wait_run(input bit poke);
    logic m_q;
    int n;
    ed = 0;
    ord = 16'h0000;
    dn = 0;
    n = 0;
    m_q = master_clock_in;
    while (busy === 1'b1 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
      ctrl_wr = poke && n == 20;
      ctrl = '{1'b1, CAL_OFFS_SELF, 1'b1};
      if (master_clock_in && !m_q) ed++;
      m_q = master_clock_in;
      if (phase != 4'h0 && phase != ord[3:0]) ord = {ord[11:0], phase};
      if (busy === 1'b1 && power_on !== 1'b1) pw_drop = 1;
      if (cal_done === 1'b1) dn = 1;
    end
  endtask : wait_run
  // Judge a finished run
  task automatic judge(input int len, input logic [15:0] o);
    check("length", ed >= len - 1 && ed <= len + 1, 1);
    check("order", ord, o);
    check("done", dn, 1);
  endtask : judge
  // Software start of one type
  task automatic soft_start(input cal_sel_e sel, input logic cv);
    @(posedge clk);
    #1 ctrl_wr = 1'b1;
    ctrl = '{~cv, sel, cv};
    @(posedge clk);
    #1 ctrl_wr = 1'b0;
    check("busy_soft", busy, 1);
  endtask : soft_start

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_power_on();
    u_host_model.set_cal(1'b0);
    u_host_model.set_sleep(1'b0);
    do_reset();
    repeat (12) @(posedge clk);
    #1 check("busy_held", busy, 0);
    check("core_rst", core_reset, 1);
    pw_drop = 0;
    u_host_model.set_cal(1'b1);
    wait_busy(10);
    wait_run(0);
    judge(POR, 16'h0842);
    check("pwr_kept", pw_drop, 0);
    repeat (12) @(posedge clk);
    #1 check("slept", power_on, 0);
    u_host_model.set_sleep(1'b1);
  endtask : t_power_on
  task automatic t_soft_all();
    for (int i = 0; i < 7; i++) begin
      err_sample = errs[i];
      soft_start(cal_sel_e'(3'(i)), 1'b0);
      wait_run(i == 0);
      judge(lens[i], ords[i]);
      check("off_trim", offset_trim, offs[i]);
      check("gain_trim", gain_trim, gains[i]);
    end
  endtask : t_soft_all
  task automatic t_pin_start();
    u_host_model.set_cal(1'b0);
    repeat (8) @(posedge clk);
    #1 check("pin_rst", core_reset, 1);
    check("pin_idle", busy, 0);
    u_host_model.set_cal(1'b1);
    wait_busy(10);
    check("pin_busy", busy, 1);
    wait_run(0);
    judge(FULL, 16'h0842);
  endtask : t_pin_start
  task automatic t_convert();
    soft_start(CAL_FULL_SELF, 1'b1);
    wait_run(0);
    check("conv_len", ed >= CONV - 1 && ed <= CONV + 1, 1);
    check("conv_ph", ord, 16'h0001);
    pd_after_conv = 1'b1;
    repeat (10) @(posedge clk);
    #1 check("pd_idle", power_on, 0);
    // Pulse low long enough to cover the power-up count
    u_host_model.conv_pulse(4 * PWRUP + 10);
    wait_busy(10);
    check("pu_conv", power_on, 1);
    wait_run(0);
    check("pin_conv", ed >= CONV - 1 && ed <= CONV + 1, 1);
    repeat (5) @(posedge clk);
    #1 check("pd_again", power_on, 0);
    pw_drop = 0;
    // Software start while down adds the power-up count
    soft_start(CAL_FULL_SELF, 1'b1);
    wait_run(0);
    check("cold_len", ed >= CONV + PWRUP - 1 && ed <= CONV + PWRUP + 1, 1);
    check("cold_pwr", pw_drop, 0);
    pd_after_conv = 1'b0;
  endtask : t_convert

  // Watchdog
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end
  // Main sequence
  initial begin
    srst = 1'b1;
    ctrl_wr = 1'b0;
    ctrl = '{1'b0, CAL_FULL_SELF, 1'b0};
    pd_after_conv = 1'b0;
    err_sample = 12'h000;
    err_total = 0;
    check_count = 0;
    do_reset();
    repeat (60) @(posedge clk);
    #1 check("no_auto", busy, 0);
    t_power_on();
    t_soft_all();
    t_pin_start();
    t_convert();
    print_verdict();
  end
endmodule : adc_calibration_sequencer_tb_top
